// ### wee_ctrl.sv
// Memory controller write checker: ECC range test, error status, interrupt and APB registers
`timescale 1ns/1ps
`include "wee_cfg.svh"
module wee_ctrl
  import wee_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  wee_wr_if.ctrl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic eccIrq,
  output logic memWrValid,
  output logic [31:0] memWrAddr,
  output logic [15:0] memWrLen,
  output logic [7:0] memWrByteEn,
  output logic memWrMerge
);
  logic rawErr;
  logic enErr;
  logic rmwEnable;
  logic [31:0] rangeStart;
  logic [31:0] rangeEnd;
  logic [31:0] wrCount;
  logic apbWr;
  logic apbRd;
  logic mapped;
  logic accepted;
  logic inRange;
  logic violation;
  logic errEvent;
  logic issue;
  logic misaligned;
  logic subQuanta;
  logic clearRaw;
  logic setEnable;
  logic clearEnable;
  logic [31:0] next_prdata;

  // Controller accepts one write per cycle and answers on the next
  assign link.wrReady = 1'b1;
  assign accepted = link.wrValid && link.wrReady;
  assign inRange = (link.wrAddr >= rangeStart) && (link.wrAddr <= rangeEnd);
  // An empty-enable trailer of one byte breaks both conditions, so it is flagged too
  assign misaligned = (link.wrAddr[2:0] != 3'h0);
  assign subQuanta = (link.wrLen[2:0] != 3'h0);
  assign violation = inRange && (misaligned || subQuanta);
  assign errEvent = accepted && violation && !rmwEnable;
  assign issue = accepted && (link.wrByteEn != 8'h00);

  // Write status back to the issuing master
  // Status rides one cycle behind the take, with no wait states
  always_ff @(posedge clk) begin
    if (rst) begin
      link.stValid <= 1'b0;
      link.stErr <= 1'b0;
    end else begin
      link.stValid <= accepted;
      link.stErr <= errEvent;
    end
  end

  // Issue to the SDRAM side; merge requested for violating writes under read-modify-write
  always_ff @(posedge clk) begin
    if (rst) begin
      memWrValid <= 1'b0;
      memWrAddr <= 32'h0000_0000;
      memWrLen <= 16'h0000;
      memWrByteEn <= 8'h00;
      memWrMerge <= 1'b0;
    end else begin
      memWrValid <= issue;
      if (issue) begin
        memWrAddr <= link.wrAddr;
        memWrLen <= link.wrLen;
        memWrByteEn <= link.wrByteEn;
        memWrMerge <= violation && rmwEnable;
      end
    end
  end

  // APB decode, zero wait states; read data is fetched in the setup cycle
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `WEE_OFF_RAW, `WEE_OFF_ENSET, `WEE_OFF_ENCLR, `WEE_OFF_ECC_CONTROL_REG: mapped = 1'b1;
      `WEE_OFF_RSTART, `WEE_OFF_REND, `WEE_OFF_WRCNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // Write-one strobes for the status and enable registers
  assign clearRaw = apbWr && (paddr == `WEE_OFF_RAW) && pwdata[`WEE_BIT_WRERR];
  assign setEnable = apbWr && (paddr == `WEE_OFF_ENSET) && pwdata[`WEE_BIT_WRERR];
  assign clearEnable = apbWr && (paddr == `WEE_OFF_ENCLR) && pwdata[`WEE_BIT_WRERR];

  // Raw status: sticky, write one to clear, a new error beats the clear
  // One flag and no count: an error that meets a set flag adds nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      rawErr <= 1'b0;
    end else if (errEvent) begin
      rawErr <= 1'b1;
    end else if (clearRaw) begin
      rawErr <= 1'b0;
    end
  end

  // Enable bit: set through the set register, dropped through the clear register
  always_ff @(posedge clk) begin
    if (rst) begin
      enErr <= 1'b0;
    end else if (setEnable) begin
      enErr <= 1'b1;
    end else if (clearEnable) begin
      enErr <= 1'b0;
    end
  end

  // ECC control: read-modify-write enable
  always_ff @(posedge clk) begin
    if (rst) begin
      rmwEnable <= 1'b0;
    end else if (apbWr && paddr == `WEE_OFF_ECC_CONTROL_REG) begin
      rmwEnable <= pwdata[`WEE_BIT_RMWEN];
    end
  end

  // Protected range, both ends inclusive
  always_ff @(posedge clk) begin
    if (rst) begin
      rangeStart <= `WEE_RST_RSTART;
      rangeEnd <= `WEE_RST_REND;
    end else if (apbWr) begin
      if (paddr == `WEE_OFF_RSTART) begin
        rangeStart <= pwdata;
      end
      if (paddr == `WEE_OFF_REND) begin
        rangeEnd <= pwdata;
      end
    end
  end

  // Count of writes actually issued to memory
  // Empty-enable writes never reach memory and are not counted
  always_ff @(posedge clk) begin
    if (rst) begin
      wrCount <= 32'h0000_0000;
    end else if (issue) begin
      wrCount <= wrCount + 32'h0000_0001;
    end
  end

  // Single shared interrupt, no source identity kept
  // It drops as soon as either the flag or the enable is cleared
  assign eccIrq = rawErr && enErr;

  // Read data for the addressed register, zero when unmapped
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (apbRd) begin
      unique case (paddr)
        `WEE_OFF_RAW: next_prdata[`WEE_BIT_WRERR] = rawErr;
        `WEE_OFF_ENSET, `WEE_OFF_ENCLR: next_prdata[`WEE_BIT_WRERR] = enErr;
        `WEE_OFF_ECC_CONTROL_REG: next_prdata[`WEE_BIT_RMWEN] = rmwEnable;
        `WEE_OFF_RSTART: next_prdata = rangeStart;
        `WEE_OFF_REND: next_prdata = rangeEnd;
        `WEE_OFF_WRCNT: next_prdata = wrCount;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data flop: loaded in the setup cycle, held through the access phase
  // A flag that changes during the access phase shows on the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apbRd) begin
      prdata <= next_prdata;
    end else if (!psel || pwrite) begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule

// ### wee_cfg.svh
// Offsets, field positions, reset values and fixed sizes of the write ECC error block
`ifndef WEE_CFG_SVH
`define WEE_CFG_SVH
`define WEE_OFF_RAW 12'h000
`define WEE_OFF_ENSET 12'h004
`define WEE_OFF_ENCLR 12'h008
`define WEE_OFF_ECC_CONTROL_REG 12'h00C
`define WEE_OFF_RSTART 12'h010
`define WEE_OFF_REND 12'h014
`define WEE_OFF_WRCNT 12'h018
`define WEE_BIT_WRERR 0
`define WEE_BIT_RMWEN 0
`define WEE_RST_RSTART 32'h8000_0000
`define WEE_RST_REND 32'hFFFF_FFFF
`define WEE_LINE_L2 16'h0080
`define WEE_LINE_L1D 16'h0040
`define WEE_STAT_DATAERR 3'h4
`endif

// ### wee_pkg.sv
// Types shared by the write ECC error block ends
package wee_pkg;
  typedef enum logic [1:0] {
    WEE_CMD_SINGLE,
    WEE_CMD_BLK_L2,
    WEE_CMD_BLK_L1D,
    WEE_CMD_GLOBAL
  } wee_cmd_t;
  typedef enum logic [1:0] {
    WEE_M_IDLE,
    WEE_M_LINE,
    WEE_M_TRAIL,
    WEE_M_WAIT
  } wee_mstate_t;
endpackage

// ### wee_wr_if.sv
// Write request and write status link between a bus master and the memory controller
`timescale 1ns/1ps
interface wee_wr_if (
  input wire logic clk
);
  logic wrValid;
  logic wrReady;
  logic [31:0] wrAddr;
  logic [15:0] wrLen;
  logic [7:0] wrByteEn;
  logic stValid;
  logic stErr;
  modport ctrl (input clk, input wrValid, output wrReady, input wrAddr, input wrLen, input wrByteEn,
    output stValid, output stErr);
  modport mst (input clk, output wrValid, input wrReady, output wrAddr, output wrLen, output wrByteEn,
    input stValid, input stErr);
endinterface

// ### wee_master.sv
// Cache controller side: line writes, trailing bounding write, first-error capture
`timescale 1ns/1ps
`include "wee_cfg.svh"
module wee_master
  import wee_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  wee_wr_if.mst link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire wee_cmd_t cmdKind,
  input wire logic [31:0] cmdAddr,
  input wire logic [15:0] cmdLen,
  input wire logic [7:0] cmdByteEn,
  input wire logic errClear,
  output logic [2:0] busErrStat,
  output logic errIrq,
  output logic cmdDone
);
  wee_mstate_t state;
  logic [31:0] lineAddr;
  logic [15:0] lineLen;
  logic [7:0] lineBe;
  logic trailNeeded;
  logic errValid;

  assign cmdReady = (state == WEE_M_IDLE);
  assign errIrq = errValid;

  // Request sequencing: one write, then the bounding write for block operations
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= WEE_M_IDLE;
      lineAddr <= 32'h0000_0000;
      lineLen <= 16'h0000;
      lineBe <= 8'h00;
      trailNeeded <= 1'b0;
      cmdDone <= 1'b0;
    end else begin
      cmdDone <= 1'b0;
      unique case (state)
        WEE_M_IDLE: begin
          if (cmdValid) begin
            lineAddr <= cmdAddr;
            lineBe <= 8'hFF;
            trailNeeded <= (cmdKind == WEE_CMD_BLK_L2) || (cmdKind == WEE_CMD_BLK_L1D);
            unique case (cmdKind)
              WEE_CMD_SINGLE: begin
                lineLen <= cmdLen;
                lineBe <= cmdByteEn;
              end
              WEE_CMD_BLK_L1D: lineLen <= `WEE_LINE_L1D;
              default: lineLen <= `WEE_LINE_L2;
            endcase
            state <= WEE_M_LINE;
          end
        end
        WEE_M_LINE: begin
          if (link.wrReady) begin
            state <= WEE_M_WAIT;
          end
        end
        WEE_M_TRAIL: begin
          if (link.wrReady) begin
            state <= WEE_M_WAIT;
          end
        end
        WEE_M_WAIT: begin
          // An error status does not stop the command; it runs to its end
          if (link.stValid) begin
            if (trailNeeded) begin
              trailNeeded <= 1'b0;
              lineAddr <= lineAddr + 32'(lineLen) - 32'h0000_0001;
              lineLen <= 16'h0001;
              lineBe <= 8'h00;
              state <= WEE_M_TRAIL;
            end else begin
              cmdDone <= 1'b1;
              state <= WEE_M_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Link drive from the held request
  assign link.wrValid = (state == WEE_M_LINE) || (state == WEE_M_TRAIL);
  assign link.wrAddr = lineAddr;
  assign link.wrLen = lineLen;
  assign link.wrByteEn = lineBe;

  // Error capture keeps only the first error until cleared; a new error beats a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      errValid <= 1'b0;
      busErrStat <= 3'h0;
    end else if (link.stValid && link.stErr && (!errValid || errClear)) begin
      errValid <= 1'b1;
      busErrStat <= `WEE_STAT_DATAERR;
    end else if (errClear) begin
      errValid <= 1'b0;
      busErrStat <= 3'h0;
    end
  end
endmodule

// ### wee_link_asserts.sv
// Checker of the write link between the cache master and the controller
`timescale 1ns/1ps
module wee_link_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire logic [31:0] wrAddr,
  input wire logic [15:0] wrLen,
  input wire logic [7:0] wrByteEn,
  input wire logic stValid,
  input wire logic stErr
);
  logic [31:0] lastEnd;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Last byte of the most recently taken write
  always_ff @(posedge clk) begin
    if (wrValid && wrReady) begin
      lastEnd <= wrAddr + 32'(wrLen) - 32'h1;
    end
  end
  chk_status_next: assert property (wrValid && wrReady |=> stValid)
    else $error("status not one cycle after take");
  chk_status_pulse: assert property (stValid |=> !stValid)
    else $error("status longer than one cycle");
  chk_ready_high: assert property (wrReady)
    else $error("ready dropped");
  chk_one_pending: assert property (wrValid && wrReady |=> !wrValid)
    else $error("request before status");
  chk_err_valid: assert property (stErr |-> stValid)
    else $error("error without status");
  chk_aligned_clean: assert property (wrValid && wrAddr[2:0] == 3'h0 && wrLen[2:0] == 3'h0 |=> !stErr)
    else $error("aligned write flagged");
  chk_outside_clean: assert property (wrValid && !wrAddr[31] |=> !stErr)
    else $error("write outside range flagged");
  chk_trailer_end: assert property (wrValid && wrByteEn == 8'h00 && wrLen == 16'h1 |-> wrAddr == lastEnd)
    else $error("trailer not at last byte");
endmodule

// ### tb_top.sv
// Bench joining master and controller over the write link
`timescale 1ns/1ps
`include "wee_cfg.svh"
module tb_top
  import wee_pkg::*;
;
  logic clk = 0, rst = 1, cmdValid = 0, errClear = 0, psel = 0, penable = 0, pwrite = 0;
  wee_cmd_t cmdKind = WEE_CMD_SINGLE;
  logic [31:0] cmdAddr = 0, pwdata = 0, prdata;
  logic [15:0] cmdLen = 0, lfsr = 16'h0031;
  logic [7:0] cmdByteEn = 0;
  logic [11:0] paddr = 0;
  logic cmdReady, errIrq, cmdDone, pready, pslverr, eccIrq, memWrValid, memWrMerge;
  logic [31:0] memWrAddr;
  logic [15:0] memWrLen;
  logic [7:0] memWrByteEn;
  logic [2:0] busErrStat;
  int n_fail = 0, total_checks = 0, cyc = 0;
  logic [58:0] expQ[$];
  wee_wr_if link (.clk(clk));
  wee_master wee_master_inst (.clk(clk), .rst(rst), .link(link.mst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .cmdByteEn(cmdByteEn), .errClear(errClear),
    .busErrStat(busErrStat), .errIrq(errIrq), .cmdDone(cmdDone));
  wee_ctrl wee_ctrl_inst (.clk(clk), .rst(rst), .link(link.ctrl), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eccIrq(eccIrq),
    .memWrValid(memWrValid), .memWrAddr(memWrAddr), .memWrLen(memWrLen), .memWrByteEn(memWrByteEn),
    .memWrMerge(memWrMerge));
  wee_link_asserts wee_link_asserts_inst (.clk(clk), .rst(rst), .wrValid(link.wrValid), .wrReady(link.wrReady),
    .wrAddr(link.wrAddr), .wrLen(link.wrLen), .wrByteEn(link.wrByteEn), .stValid(link.stValid),
    .stErr(link.stErr));
  // Clock at 40 MHz
  initial forever #12.5 clk = ~clk;
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer, held until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(0, a, 0, r, e);
    check($sformatf("reg %h", a), r, x);
  endtask
  // Hands one command to the master and waits for its completion
  task automatic cmd(wee_cmd_t k, logic [31:0] a, logic [15:0] n, logic [7:0] be);
    @(posedge clk);
    cmdValid <= 1;
    cmdKind <= k;
    cmdAddr <= a;
    cmdLen <= n;
    cmdByteEn <= be;
    @(posedge clk);
    while (cmdReady !== 1'b1) @(posedge clk);
    cmdValid <= 0;
    do @(posedge clk); while (cmdDone !== 1'b1);
    #1;
  endtask
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Packs one expectation: error, issued, merged, then the issued address, length and enables
  function automatic logic [58:0] note(logic er, logic iss, logic mg, logic [31:0] a, logic [15:0] n,
    logic [7:0] be);
    return {er, iss, mg, a, n, be};
  endfunction
  // Each write status is compared with the oldest expectation
  always @(posedge clk) begin
    logic [58:0] x;
    if (!rst && link.stValid === 1'b1) begin
      if (expQ.size() == 0) check("extra status", 1, 0);
      else begin
        x = expQ.pop_front();
        check("stErr", link.stErr, x[58]);
        check("memWrValid", memWrValid, x[57]);
        check("memWrMerge", memWrMerge & memWrValid, x[56]);
        if (x[57]) begin
          check("memWrAddr", memWrAddr, x[55:24]);
          check("memWrLen", memWrLen, x[23:8]);
          check("memWrByteEn", memWrByteEn, x[7:0]);
        end
      end
    end
  end
  // Cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] d;
    logic e;
    logic [15:0] b;
    logic [15:0] n;
    logic viol;
    repeat (12) @(posedge clk);
    rst <= 0;
    rd(`WEE_OFF_RAW, 0);
    rd(`WEE_OFF_ENSET, 0);
    rd(`WEE_OFF_RSTART, `WEE_RST_RSTART);
    apb(0, 12'h01C, 0, d, e);
    check("unmapped", e, 1);
    $display("test reset done");
    expQ = '{note(1'b0, 1'b1, 1'b0, 32'h8000_0100, `WEE_LINE_L2, 8'hFF),
      note(1'b1, 1'b0, 1'b0, 32'h8000_017F, 16'h0001, 8'h00)};
    cmd(WEE_CMD_BLK_L2, 32'h8000_0100, 0, 0);
    check("busErrStat", busErrStat, `WEE_STAT_DATAERR);
    check("errIrq", errIrq, 1);
    check("eccIrq", eccIrq, 0);
    rd(`WEE_OFF_RAW, 1);
    wr(`WEE_OFF_RAW, 0);
    rd(`WEE_OFF_RAW, 1);
    wr(`WEE_OFF_ENSET, 1);
    check("eccIrq", eccIrq, 1);
    wr(`WEE_OFF_RAW, 1);
    check("eccIrq", eccIrq, 0);
    $display("test block line done");
    expQ = '{note(1'b0, 1'b1, 1'b0, 32'h8000_0200, `WEE_LINE_L1D, 8'hFF),
      note(1'b1, 1'b0, 1'b0, 32'h8000_023F, 16'h0001, 8'h00)};
    cmd(WEE_CMD_BLK_L1D, 32'h8000_0200, 0, 0);
    check("eccIrq", eccIrq, 1);
    @(posedge clk);
    errClear <= 1;
    @(posedge clk);
    errClear <= 0;
    #1;
    check("busErrStat", busErrStat, 0);
    wr(`WEE_OFF_ENCLR, 1);
    check("eccIrq", eccIrq, 0);
    wr(`WEE_OFF_RAW, 1);
    expQ = '{note(1'b0, 1'b1, 1'b0, 32'h8000_0300, `WEE_LINE_L2, 8'hFF)};
    cmd(WEE_CMD_GLOBAL, 32'h8000_0300, 0, 0);
    rd(`WEE_OFF_RAW, 0);
    apb(0, `WEE_OFF_WRCNT, 0, d, e);
    expQ = '{note(1'b0, 1'b0, 1'b0, 32'h8000_0400, 16'h0008, 8'h00)};
    cmd(WEE_CMD_SINGLE, 32'h8000_0400, 16'h8, 8'h00);
    rd(`WEE_OFF_WRCNT, d);
    $display("test global and empty done");
    for (int m = 0; m < 2; m++) begin
      wr(`WEE_OFF_RAW, 1);
      wr(`WEE_OFF_ECC_CONTROL_REG, m);
      repeat (6) begin
        lfsr = nxt(lfsr);
        b = lfsr;
        lfsr = nxt(lfsr);
        d = {b, lfsr} & (lfsr[15] ? ~32'h7 : ~32'h0);
        n = lfsr[14] ? 16'h10 : 16'(lfsr[3:0]) + 16'h1;
        viol = d[31] && (d[2:0] != 3'h0 || n[2:0] != 3'h0);
        expQ.push_back(note(viol && m == 0, 1'b1, viol && m == 1, d, n, b[7:0] | 8'h01));
        cmd(WEE_CMD_SINGLE, d, n, b[7:0] | 8'h01);
      end
    end
    rd(`WEE_OFF_RAW, 0);
    expQ = '{note(1'b0, 1'b1, 1'b1, 32'h8000_0604, 16'h0005, 8'h0F)};
    cmd(WEE_CMD_SINGLE, 32'h8000_0604, 16'h0005, 8'h0F);
    expQ = '{note(1'b0, 1'b1, 1'b0, 32'h8000_0500, `WEE_LINE_L2, 8'hFF),
      note(1'b0, 1'b0, 1'b0, 32'h8000_057F, 16'h0001, 8'h00)};
    cmd(WEE_CMD_BLK_L2, 32'h8000_0500, 0, 0);
    rd(`WEE_OFF_RAW, 0);
    check("queue left", expQ.size(), 0);
    $display("test random and merge done");
    give_verdict();
  end
endmodule
